// ==== include/fes_regs.svh ====
// Constants for the enable-select and pin-mux block
`ifndef FES_REGS_SVH
`define FES_REGS_SVH
`define FES_NUM_BLK 8
`define FES_SEL_W 4
// Block indices inside the enable vectors
`define FES_BLK_REG9 0
`define FES_BLK_REG10 1
`define FES_BLK_BUCK2 2
`define FES_BLK_OSC1 3
`define FES_BLK_OSC2 4
`define FES_BLK_USB 5
`define FES_BLK_SIM 6
`define FES_BLK_SPARE 7
// Synchronised pin indices
`define FES_NUM_PIN 8
`define FES_PIN_SLEEP_N 0
`define FES_PIN_EN0 1
`define FES_PIN_RST_HOST 4
`define FES_PIN_CLK_HOST 5
`define FES_PIN_IO_HOST 6
`define FES_PIN_IO_CARD 7
// USB pin code fields in the packed pin configuration
`define FES_USB_OE 0
`define FES_USB_DP 1
`define FES_USB_SEM 2
`define FES_USB_RCV 3
`define FES_USB_SUSP 4
// Reset values of the configuration fields
`define FES_SEL_RST 4'h0
`define FES_PERMIT_RST 8'h00
`define FES_PINCFG_RST 4'h0
// Warm-up times and their cycle counts
`define FES_CLK_NS 10
`define FES_WARM_A_US 1
`define FES_WARM_B_US 21
`define FES_WARM_C_US 41
`define FES_WARM_D_US 61
`define FES_WARM_A_CYC ((`FES_WARM_A_US * 1000 + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_WARM_B_CYC ((`FES_WARM_B_US * 1000 + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_WARM_C_CYC ((`FES_WARM_C_US * 1000 + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_WARM_D_CYC ((`FES_WARM_D_US * 1000 + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_WARM_CNT_W 13
`endif

// ==== include/fes_pkg.sv ====
// Types for the enable-select and pin-mux block
`default_nettype none
package fes_pkg;
	typedef enum logic [3:0] {
		SEL_OFF = 4'b0000,
		SEL_WORK = 4'b0001,
		SEL_CTRL0 = 4'b0010,
		SEL_CTRL1 = 4'b0011,
		SEL_CTRL2 = 4'b0100,
		SEL_PIN0 = 4'b0101,
		SEL_PIN1 = 4'b0110,
		SEL_PIN2 = 4'b0111
	} fes_sel_t;
	typedef enum logic {
		UNIT_IDLE = 1'b0,
		UNIT_SLEEP = 1'b1
	} fes_unit_t;
	typedef enum logic [1:0] {
		OWN_NONE = 2'b00,
		OWN_HOST = 2'b01,
		OWN_CARD = 2'b10,
		OWN_SETTLE = 2'b11
	} fes_owner_t;
endpackage
`default_nettype wire

// ==== logic/fes_warmup.sv ====
// Oscillator buffer warm-up delay before output enable
`include "fes_regs.svh"
`default_nettype none
module fes_warmup #(
	parameter int CYC_C = `FES_WARM_C_CYC,
	parameter int CYC_D = `FES_WARM_D_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [3:0] code,
	output logic out_en
);
	logic [`FES_WARM_CNT_W-1:0] cnt;
	logic [`FES_WARM_CNT_W-1:0] target;

	// Code pairs from 1000 upward pick the wait; other codes use the wait of pair 1000
	always_comb begin
		target = `FES_WARM_CNT_W'(`FES_WARM_A_CYC);
		if (code[3]) begin
			case (code[2:1])
				2'b00: target = `FES_WARM_CNT_W'(`FES_WARM_A_CYC);
				2'b01: target = `FES_WARM_CNT_W'(`FES_WARM_B_CYC);
				2'b10: target = `FES_WARM_CNT_W'(CYC_C);
				default: target = `FES_WARM_CNT_W'(CYC_D);
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !enable) begin
			cnt <= `FES_WARM_CNT_W'h0000;
			out_en <= 1'b0;
		end else if (cnt < target) begin
			cnt <= cnt + `FES_WARM_CNT_W'h0001;
			out_en <= 1'b0;
		end else begin
			out_en <= 1'b1;
		end
	end

	AST_WARM_EARLY: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(out_en) |-> $past(cnt >= target))
		else $error("Oscillator output enabled before warm-up ended");
endmodule // fes_warmup
`default_nettype wire

// ==== logic/fes_top.sv ====
// Enable source selection, sleep gating and multifunction pin routing
`include "fes_regs.svh"
`default_nettype none
// Behaviour
// - Each enable-capable block has its own 4-bit selector choosing its enable.
// - Sources include control bits of three control bytes and enable pins.
// - One source may drive any number of blocks at once.
// - In sleep, a block without sleep permission is forced off.
// - With sleep permission, enable follows the selected source regardless of sleep.
// - Code 0001 enables the block whenever the unit is working.
// - Code 0010 enables the block when control byte zero bits [1:0] are 11.
// - Each multifunction pin takes a code selecting analog, converter or digital use.
// - The card level shifter connects only when all six pins select it.
// - USB connects 5-wire or 3-wire only when all used pins pick that role.
// - Function enables shut a function down without changing its pin connection.
// - USB codes 1000-1011 are 3-pin roles, 1100-1111 are 5-pin roles.
// - First oscillator input code pairs select 1, 21, 41 or 61 us warm-up.
// - Second oscillator input code pairs select the same warm-up waits.
// - Unit enters sleep from idle when the sleep request pin goes low.
module fes_top #(
	parameter int WARM_C_CYC = `FES_WARM_C_CYC,
	parameter int WARM_D_CYC = `FES_WARM_D_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Sleep request and enable sources
	input wire logic SLEEP_REQ_N,
	input wire logic [7:0] CTRL_BYTE0,
	input wire logic [7:0] CTRL_BYTE1,
	input wire logic [7:0] CTRL_BYTE2,
	input wire logic [2:0] ENABLE_PIN,
	// Selector and permit configuration
	input wire logic [`FES_NUM_BLK*`FES_SEL_W-1:0] BLOCK_ENABLE_SELECT,
	input wire logic [`FES_NUM_BLK-1:0] SLEEP_PERMIT,
	// Pin function codes
	input wire logic [23:0] CARD_PIN_CFG,
	input wire logic [19:0] USB_PIN_CFG,
	input wire logic USB_FOUR_WIRE,
	input wire logic [3:0] OSC_BUFFER_ONE_INPUT_PIN_CFG,
	input wire logic [3:0] OSC_BUFFER_TWO_INPUT_PIN_CFG,
	// Block enables and status
	output logic [`FES_NUM_BLK-1:0] BLOCK_ENABLE,
	output logic UNIT_SLEEP,
	output logic OSC_BUFFER_ONE_OUT_EN,
	output logic OSC_BUFFER_TWO_OUT_EN,
	output logic CARD_SHIFTER_CONN,
	output logic USB_CONN_THREE_WIRE,
	output logic USB_CONN_FIVE_WIRE,
	output logic USB_ACTIVE,
	// Card level shifter pins
	input wire logic CARD_RESET_HOST_PIN,
	input wire logic CARD_CLOCK_HOST_PIN,
	input wire logic CARD_IO_HOST_PIN_I,
	output logic CARD_IO_HOST_PIN_O,
	output logic CARD_IO_HOST_PIN_OE,
	output logic CARD_RESET_CARD_PIN,
	output logic CARD_CLOCK_CARD_PIN,
	input wire logic CARD_IO_CARD_PIN_I,
	output logic CARD_IO_CARD_PIN_O,
	output logic CARD_IO_CARD_PIN_OE
);
	logic [`FES_NUM_PIN-1:0] pin_raw;
	logic [`FES_NUM_PIN-1:0] sync1;
	logic [`FES_NUM_PIN-1:0] sync2;
	logic [`FES_NUM_PIN-1:0] sync3;
	logic [`FES_NUM_PIN-1:0] pin;
	logic [`FES_SEL_W-1:0] sel_q [`FES_NUM_BLK];
	logic [`FES_NUM_BLK-1:0] permit_q;
	logic [`FES_NUM_BLK-1:0] src;
	logic [23:0] card_cfg_q;
	logic [19:0] usb_cfg_q;
	logic [3:0] osc1_cfg_q;
	logic [3:0] osc2_cfg_q;
	fes_pkg::fes_unit_t unit;
	fes_pkg::fes_owner_t owner;
	fes_pkg::fes_owner_t next_owner;
	logic card_act;
	logic usb3_ok;
	logic usb5_ok;

	assign pin_raw = {CARD_IO_CARD_PIN_I, CARD_IO_HOST_PIN_I, CARD_CLOCK_HOST_PIN,
		CARD_RESET_HOST_PIN, ENABLE_PIN, SLEEP_REQ_N};

	// Three-stage pin synchronisers with agreement filter
	genvar p;
	generate
		for (p = 0; p < `FES_NUM_PIN; p++) begin : g_sync
			always_ff @(posedge CLK) begin
				if (!RST_N) begin
					sync1[p] <= 1'b1;
					sync2[p] <= 1'b1;
					sync3[p] <= 1'b1;
					pin[p] <= 1'b1;
				end else begin
					sync1[p] <= pin_raw[p];
					sync2[p] <= sync1[p];
					sync3[p] <= sync2[p];
					if (sync2[p] == sync3[p]) begin
						pin[p] <= sync3[p];
					end
				end
			end
		end
	endgenerate

	// Configuration capture
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			permit_q <= `FES_PERMIT_RST;
			card_cfg_q <= {6{`FES_PINCFG_RST}};
			usb_cfg_q <= {5{`FES_PINCFG_RST}};
			osc1_cfg_q <= `FES_PINCFG_RST;
			osc2_cfg_q <= `FES_PINCFG_RST;
		end else begin
			permit_q <= SLEEP_PERMIT;
			card_cfg_q <= CARD_PIN_CFG;
			usb_cfg_q <= USB_PIN_CFG;
			osc1_cfg_q <= OSC_BUFFER_ONE_INPUT_PIN_CFG;
			osc2_cfg_q <= OSC_BUFFER_TWO_INPUT_PIN_CFG;
		end
	end

	// Unit sleep state
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			unit <= fes_pkg::UNIT_IDLE;
		end else begin
			case (unit)
				fes_pkg::UNIT_IDLE: if (!pin[`FES_PIN_SLEEP_N]) unit <= fes_pkg::UNIT_SLEEP;
				fes_pkg::UNIT_SLEEP: if (pin[`FES_PIN_SLEEP_N]) unit <= fes_pkg::UNIT_IDLE;
				default: unit <= fes_pkg::UNIT_IDLE;
			endcase
		end
	end
	assign UNIT_SLEEP = (unit == fes_pkg::UNIT_SLEEP);

	// Per-block source selection and sleep gating
	genvar b;
	generate
		for (b = 0; b < `FES_NUM_BLK; b++) begin : g_blk
			always_ff @(posedge CLK) begin
				if (!RST_N) begin
					sel_q[b] <= `FES_SEL_RST;
				end else begin
					sel_q[b] <= BLOCK_ENABLE_SELECT[b*`FES_SEL_W +: `FES_SEL_W];
				end
			end

			// Every block decodes the same shared sources
			always_comb begin
				case (sel_q[b])
					fes_pkg::SEL_WORK: src[b] = 1'b1;
					fes_pkg::SEL_CTRL0: src[b] = &CTRL_BYTE0[1:0];
					fes_pkg::SEL_CTRL1: src[b] = CTRL_BYTE1[0];
					fes_pkg::SEL_CTRL2: src[b] = CTRL_BYTE2[0];
					fes_pkg::SEL_PIN0: src[b] = pin[`FES_PIN_EN0];
					fes_pkg::SEL_PIN1: src[b] = pin[`FES_PIN_EN0+1];
					fes_pkg::SEL_PIN2: src[b] = pin[`FES_PIN_EN0+2];
					default: src[b] = 1'b0;
				endcase
			end

			always_ff @(posedge CLK) begin
				if (!RST_N) begin
					BLOCK_ENABLE[b] <= 1'b0;
				end else begin
					BLOCK_ENABLE[b] <= src[b] && (permit_q[b] || !UNIT_SLEEP);
				end
			end

			AST_SLEEP_GATE: assert property (@(posedge CLK) disable iff (!RST_N)
				UNIT_SLEEP && !permit_q[b] |=> !BLOCK_ENABLE[b])
				else $error("Block enabled in sleep without permission");
			AST_PERMIT_FOLLOW: assert property (@(posedge CLK) disable iff (!RST_N)
				permit_q[b] |=> BLOCK_ENABLE[b] == $past(src[b]))
				else $error("Permitted block does not follow its source");
			AST_UNDEF_OFF: assert property (@(posedge CLK) disable iff (!RST_N)
				sel_q[b][3] |=> !BLOCK_ENABLE[b])
				else $error("Undefined selector enabled a block");
			AST_WORK_ON: assert property (@(posedge CLK) disable iff (!RST_N)
				sel_q[b] == fes_pkg::SEL_WORK && !UNIT_SLEEP |=> BLOCK_ENABLE[b])
				else $error("Working-state code failed to enable block");
		end
	endgenerate

	AST_CTRL0: assert property (@(posedge CLK) disable iff (!RST_N)
		sel_q[0] == fes_pkg::SEL_CTRL0 && CTRL_BYTE0[1:0] == 2'b11 && !UNIT_SLEEP
		|=> BLOCK_ENABLE[0])
		else $error("Control byte zero code failed to enable block");
	AST_SLEEP_ENTER: assert property (@(posedge CLK) disable iff (!RST_N)
		!UNIT_SLEEP && !pin[`FES_PIN_SLEEP_N] |=> UNIT_SLEEP)
		else $error("Sleep request ignored in idle");

	// Oscillator buffer warm-up
	fes_warmup #(.CYC_C(WARM_C_CYC), .CYC_D(WARM_D_CYC)) u_warm_one (
		.clk(CLK),
		.rst_n(RST_N),
		.enable(BLOCK_ENABLE[`FES_BLK_OSC1]),
		.code(osc1_cfg_q),
		.out_en(OSC_BUFFER_ONE_OUT_EN)
	);
	fes_warmup #(.CYC_C(WARM_C_CYC), .CYC_D(WARM_D_CYC)) u_warm_two (
		.clk(CLK),
		.rst_n(RST_N),
		.enable(BLOCK_ENABLE[`FES_BLK_OSC2]),
		.code(osc2_cfg_q),
		.out_en(OSC_BUFFER_TWO_OUT_EN)
	);

	// Multi-pin connection checks
	always_comb begin
		usb3_ok = 1'b1;
		usb5_ok = 1'b1;
		for (int i = `FES_USB_OE; i <= `FES_USB_SEM; i++) begin
			usb3_ok = usb3_ok && (usb_cfg_q[i*4+3 -: 2] == 2'b10);
			usb5_ok = usb5_ok && (usb_cfg_q[i*4+3 -: 2] == 2'b11);
		end
		usb5_ok = usb5_ok && (usb_cfg_q[`FES_USB_RCV*4+3 -: 2] == 2'b11);
		usb5_ok = usb5_ok && (USB_FOUR_WIRE || usb_cfg_q[`FES_USB_SUSP*4+3 -: 2] == 2'b11);
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			CARD_SHIFTER_CONN <= 1'b0;
			USB_CONN_THREE_WIRE <= 1'b0;
			USB_CONN_FIVE_WIRE <= 1'b0;
			USB_ACTIVE <= 1'b0;
		end else begin
			CARD_SHIFTER_CONN <= &{card_cfg_q[23], card_cfg_q[19], card_cfg_q[15],
				card_cfg_q[11], card_cfg_q[7], card_cfg_q[3]};
			USB_CONN_THREE_WIRE <= usb3_ok;
			USB_CONN_FIVE_WIRE <= usb5_ok;
			USB_ACTIVE <= (USB_CONN_THREE_WIRE || USB_CONN_FIVE_WIRE)
				&& BLOCK_ENABLE[`FES_BLK_USB];
		end
	end

	AST_CARD_CONN: assert property (@(posedge CLK) disable iff (!RST_N)
		CARD_SHIFTER_CONN |-> $past(card_cfg_q[3] && card_cfg_q[7] && card_cfg_q[11]
		&& card_cfg_q[15] && card_cfg_q[19] && card_cfg_q[23]))
		else $error("Shifter connected with a pin not selecting it");
	AST_USB_EXCL: assert property (@(posedge CLK) disable iff (!RST_N)
		!(USB_CONN_THREE_WIRE && USB_CONN_FIVE_WIRE))
		else $error("USB connected in both wire modes");
	AST_USB_RANGE: assert property (@(posedge CLK) disable iff (!RST_N)
		USB_CONN_THREE_WIRE |-> $past(usb_cfg_q[7:6] == 2'b10))
		else $error("Three-wire USB outside its code range");
	AST_RESET_DEF: assert property (@(posedge CLK)
		$past(!RST_N) && RST_N |-> !CARD_SHIFTER_CONN && !USB_CONN_FIVE_WIRE
		&& BLOCK_ENABLE == '0 && permit_q == `FES_PERMIT_RST)
		else $error("Configuration not at default after reset");

	// Card level shifter routing with bus ownership for the shared data line
	assign card_act = CARD_SHIFTER_CONN && BLOCK_ENABLE[`FES_BLK_SIM];

	always_comb begin
		next_owner = owner;
		case (owner)
			fes_pkg::OWN_NONE: begin
				if (!card_act) next_owner = fes_pkg::OWN_NONE;
				else if (!pin[`FES_PIN_IO_HOST]) next_owner = fes_pkg::OWN_HOST;
				else if (!pin[`FES_PIN_IO_CARD]) next_owner = fes_pkg::OWN_CARD;
			end
			fes_pkg::OWN_HOST: if (!card_act || pin[`FES_PIN_IO_HOST]) next_owner = fes_pkg::OWN_SETTLE;
			fes_pkg::OWN_CARD: if (!card_act || pin[`FES_PIN_IO_CARD]) next_owner = fes_pkg::OWN_SETTLE;
			default: begin
				// Wait for both sides high so our own drive is not mirrored back
				if (pin[`FES_PIN_IO_HOST] && pin[`FES_PIN_IO_CARD]) next_owner = fes_pkg::OWN_NONE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			owner <= fes_pkg::OWN_NONE;
			CARD_RESET_CARD_PIN <= 1'b0;
			CARD_CLOCK_CARD_PIN <= 1'b0;
			CARD_IO_CARD_PIN_OE <= 1'b0;
			CARD_IO_HOST_PIN_OE <= 1'b0;
		end else begin
			owner <= next_owner;
			CARD_RESET_CARD_PIN <= card_act && pin[`FES_PIN_RST_HOST];
			CARD_CLOCK_CARD_PIN <= card_act && pin[`FES_PIN_CLK_HOST];
			CARD_IO_CARD_PIN_OE <= (next_owner == fes_pkg::OWN_HOST);
			CARD_IO_HOST_PIN_OE <= (next_owner == fes_pkg::OWN_CARD);
		end
	end
	// Open-drain data lines only ever pull low
	assign CARD_IO_CARD_PIN_O = 1'b0;
	assign CARD_IO_HOST_PIN_O = 1'b0;

	AST_CARD_ROUTE: assert property (@(posedge CLK) disable iff (!RST_N)
		card_act |=> CARD_RESET_CARD_PIN == $past(pin[`FES_PIN_RST_HOST])
		&& CARD_CLOCK_CARD_PIN == $past(pin[`FES_PIN_CLK_HOST]))
		else $error("Card side does not mirror host reset and clock");

	COV_SLEEP_GATED: cover property (@(posedge CLK) disable iff (!RST_N)
		UNIT_SLEEP && !permit_q[`FES_BLK_BUCK2] && sel_q[`FES_BLK_BUCK2] == fes_pkg::SEL_WORK);
	COV_GROUP_ON: cover property (@(posedge CLK) disable iff (!RST_N)
		BLOCK_ENABLE[2:0] == 3'b111 && $past(BLOCK_ENABLE[2:0] == 3'b000));
	COV_USB_FIVE: cover property (@(posedge CLK) disable iff (!RST_N) USB_ACTIVE && USB_CONN_FIVE_WIRE);
	COV_CARD_HOST_LOW: cover property (@(posedge CLK) disable iff (!RST_N) CARD_IO_CARD_PIN_OE);
endmodule // fes_top
`default_nettype wire

// ==== testbench/fes_host_model.sv ====
// Host-side model driving the level shifter pins of the block
`default_nettype none
module fes_host_model (
	// Clock and commands from the bench
	input wire logic clk,
	input wire logic run_clk,
	input wire logic rst_level,
	input wire logic pull_low,
	// Device side
	input wire logic dev_oe,
	output logic rst_pin,
	output logic clk_pin,
	output logic io_line
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] div = 2'b00;
	initial begin
		rst_pin = 1'b0;
		clk_pin = 1'b0;
	end
	// Card clock stands still outside frames; each level lasts four cycles to pass the pin filter
	always @(posedge clk) begin
		rst_pin <= #1 rst_level;
		div <= run_clk ? div + 2'b01 : 2'b00;
		if (run_clk && div == 2'b11) clk_pin <= #1 !clk_pin;
	end
	// Open-drain line with pull-up
	assign io_line = !(pull_low || dev_oe);
endmodule // fes_host_model
`default_nettype wire

// ==== testbench/feature_enable_select_and_pin_mux_tb.sv ====
// Self-checking bench for the enable-select and pin-mux block
`include "fes_regs.svh"
`default_nettype none
module feature_enable_select_and_pin_mux_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WC = 20;
	localparam int WD = 30;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic SLEEP_REQ_N = 1'b1;
	logic [7:0] c0 = 8'h00, c1 = 8'h00, c2 = 8'h00;
	logic [2:0] pins = 3'h0;
	logic [31:0] sel = 32'h0000_0000;
	logic [7:0] permit = 8'h00;
	logic [23:0] card_cfg = 24'h00_0000;
	logic [19:0] usb_cfg = 20'h0_0000;
	logic four = 1'b0;
	logic [3:0] o1 = 4'h0, o2 = 4'h0;
	logic run_clk = 1'b0, rst_level = 1'b0, pull_low = 1'b0, card_pull = 1'b0;
	logic [7:0] BLOCK_ENABLE;
	logic UNIT_SLEEP, OSC1, OSC2, CONN, U3, U5, UACT;
	logic rst_h, clk_h, io_h, io_h_oe, rst_c, clk_c, io_c_oe;
	int mismatches = 0;
	int cmp_count = 0;
	always #5 CLK = !CLK;
	fes_top #(.WARM_C_CYC(WC), .WARM_D_CYC(WD)) uut (.CLK(CLK), .RST_N(RST_N),
		.SLEEP_REQ_N(SLEEP_REQ_N), .CTRL_BYTE0(c0), .CTRL_BYTE1(c1), .CTRL_BYTE2(c2),
		.ENABLE_PIN(pins), .BLOCK_ENABLE_SELECT(sel), .SLEEP_PERMIT(permit),
		.CARD_PIN_CFG(card_cfg), .USB_PIN_CFG(usb_cfg), .USB_FOUR_WIRE(four),
		.OSC_BUFFER_ONE_INPUT_PIN_CFG(o1), .OSC_BUFFER_TWO_INPUT_PIN_CFG(o2),
		.BLOCK_ENABLE(BLOCK_ENABLE), .UNIT_SLEEP(UNIT_SLEEP), .OSC_BUFFER_ONE_OUT_EN(OSC1),
		.OSC_BUFFER_TWO_OUT_EN(OSC2), .CARD_SHIFTER_CONN(CONN), .USB_CONN_THREE_WIRE(U3),
		.USB_CONN_FIVE_WIRE(U5), .USB_ACTIVE(UACT), .CARD_RESET_HOST_PIN(rst_h),
		.CARD_CLOCK_HOST_PIN(clk_h), .CARD_IO_HOST_PIN_I(io_h), .CARD_IO_HOST_PIN_O(),
		.CARD_IO_HOST_PIN_OE(io_h_oe), .CARD_RESET_CARD_PIN(rst_c),
		.CARD_CLOCK_CARD_PIN(clk_c), .CARD_IO_CARD_PIN_I(!(io_c_oe || card_pull)),
		.CARD_IO_CARD_PIN_O(), .CARD_IO_CARD_PIN_OE(io_c_oe));
	fes_host_model host (.clk(CLK), .run_clk(run_clk), .rst_level(rst_level),
		.pull_low(pull_low), .dev_oe(io_h_oe), .rst_pin(rst_h), .clk_pin(clk_h),
		.io_line(io_h));
	task automatic step(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Expected enable of one block from its selector and sources
	function automatic logic exp_en(input logic [3:0] s, input logic p);
		logic src;
		case (s)
			4'h1: src = 1'b1;
			4'h2: src = &c0[1:0];
			4'h3: src = c1[0];
			4'h4: src = c2[0];
			4'h5, 4'h6, 4'h7: src = pins[s - 4'h5];
			default: src = 1'b0;
		endcase
		return src && (p || SLEEP_REQ_N);
	endfunction
	function automatic int warm_cyc(input logic [3:0] code);
		case (code[2:1])
			2'b00: return `FES_WARM_A_CYC;
			2'b01: return `FES_WARM_B_CYC;
			2'b10: return WC;
			default: return WD;
		endcase
	endfunction
	// Warm-up from enable rise to output enable
	task automatic warm(input int osc, input logic [3:0] code);
		int n;
		if (osc == 0) o1 = code;
		else o2 = code;
		c1[0] = 1'b0;
		step(5);
		c1[0] = 1'b1;
		n = 0;
		while (BLOCK_ENABLE[3 + osc] !== 1'b1 && n < 10) begin
			step(1);
			n++;
		end
		n = 0;
		while ((osc == 0 ? OSC1 : OSC2) !== 1'b1 && n < 8000) begin
			step(1);
			n++;
		end
		chk(n, warm_cyc(code) + 1);
	endtask
	initial begin
		#500000;
		mismatches++;
		complete_run();
	end
	initial begin
		logic [3:0] nib;
		logic t3, t5;
		void'($urandom(21538));
		step(2);
		chk({BLOCK_ENABLE, CONN, U3, U5, UACT, OSC1, OSC2}, 0);
		RST_N = 1'b1;
		step(6);
		// Random selectors, permits and sources, idle then sleep
		for (int i = 0; i < 40; i++) begin
			SLEEP_REQ_N = (i < 20);
			for (int b = 0; b < 8; b++) sel[4*b +: 4] = (i % 20 == 0) ? 4'h2 : 4'($urandom);
			permit = 8'($urandom);
			c0 = (i % 20 == 0) ? 8'h03 : 8'($urandom);
			c1 = 8'($urandom);
			c2 = 8'($urandom);
			pins = 3'($urandom);
			step(10);
			chk(UNIT_SLEEP, !SLEEP_REQ_N);
			for (int b = 0; b < 8; b++) chk(BLOCK_ENABLE[b], exp_en(sel[4*b +: 4], permit[b]));
		end
		SLEEP_REQ_N = 1'b1;
		// Level shifter: one pin missing, then all six selected
		sel = 32'h0100_0000 | 32'h0001_1000 | 32'h0010_0000;
		for (int k = 0; k < 6; k++) card_cfg[4*k +: 4] = {1'b1, 3'($urandom)};
		card_cfg[4*($urandom % 6) + 3] = 1'b0;
		step(6);
		chk(CONN, 1'b0);
		card_cfg = card_cfg | 24'h88_8888;
		rst_level = 1'b1;
		step(10);
		chk({CONN, rst_c}, 2'b11);
		// Three host clock toggles, then the clock stops high
		run_clk = 1'b1;
		step(13);
		run_clk = 1'b0;
		step(10);
		chk({clk_h, clk_c}, 2'b11);
		pull_low = 1'b1;
		step(10);
		chk(io_c_oe, 1'b1);
		pull_low = 1'b0;
		step(12);
		chk(io_c_oe, 1'b0);
		// Card side pulls the data line, host side must follow
		card_pull = 1'b1;
		step(10);
		chk({io_h_oe, io_h}, 2'b10);
		card_pull = 1'b0;
		step(12);
		chk({io_h_oe, io_h}, 2'b01);
		sel[27:24] = 4'h0;
		step(10);
		chk({CONN, rst_c}, 2'b10);
		// USB pin roles, biased alternately toward 3-pin and 5-pin codes
		for (int i = 0; i < 40; i++) begin
			for (int k = 0; k < 5; k++) begin
				nib = 4'($urandom);
				nib[3:2] = ($urandom % 6 == 0) ? 2'($urandom) : (i % 2 ? 2'b11 : 2'b10);
				usb_cfg[4*k +: 4] = nib;
			end
			four = 1'($urandom);
			step(6);
			t3 = usb_cfg[3:2] == 2'b10 && usb_cfg[7:6] == 2'b10 && usb_cfg[11:10] == 2'b10;
			t5 = usb_cfg[3:2] == 2'b11 && usb_cfg[7:6] == 2'b11 && usb_cfg[11:10] == 2'b11
				&& usb_cfg[15:14] == 2'b11 && (four || usb_cfg[19:18] == 2'b11);
			chk({U3, U5, UACT}, {t3, t5, t3 || t5});
		end
		// Warm-up for codes 1000-1111 of both oscillator inputs
		sel[15:12] = 4'h3;
		sel[19:16] = 4'h3;
		for (int c = 8; c < 16; c++) warm(0, 4'(c));
		for (int c = 15; c > 7; c--) warm(1, 4'(c));
		run_clk = 1'b1;
		RST_N = 1'b0;
		step(2);
		chk({BLOCK_ENABLE, CONN, U3, U5, UACT, OSC1, OSC2}, 0);
		complete_run();
	end
endmodule // feature_enable_select_and_pin_mux_tb
`default_nettype wire
